/* design/icg_pkg.sv */
/*
 * Constants, types and register map of the group-two priority, edge select
 * and shared source select part of the interrupt controller.
 * Assumes a byte-wide register port and a core that takes one request
 * at a time and acknowledges it with a one-cycle pulse.
 */
// Operation
// - Enable bit pair decodes to priority level
// - High enable bits 3..0 map port C 3..0
// - Low enable bits 3..0 map port C 3..0
// - Select bit zero means falling edge request
// - Select bit one means rising edge request
// - Bit 7 picks pin 7 or voltage detector
// - Bit 6 picks pin 6 or comparator
// - Source switch may itself raise request
// - Master enable gates group-two requests to core; PA_REQ and IRQ_OUT are not gated
// - Master enable set and cleared by events
// - Group-two pending bit reads one while waiting
package icg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [11:0] OFS_G2_PEND = 12'hfc6;
   localparam logic [11:0] OFS_G2_PRIO_HIGH = 12'hfc7;
   localparam logic [11:0] OFS_G2_PRIO_LOW = 12'hfc8;
   localparam logic [11:0] OFS_EDGE_POL = 12'hfcd;
   localparam logic [11:0] OFS_SHARED_SEL = 12'hfce;
   localparam logic [11:0] OFS_IRQ_CTRL = 12'hfcf;
   localparam logic [11:0] OFS_EDGE_STAT = 12'hfd0;
   localparam logic [11:0] OFS_EDGE_MASK = 12'hfd1;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_MASTER_EN = 1'b0;

   // Field positions
   localparam int POS_MASTER_EN = 7;
   localparam int POS_PIN7_OR_LVD = 7;
   localparam int POS_PIN6_OR_CMP = 6;

   // Source counts
   localparam int PORTA_PINS = 8;
   localparam int G2_SRCS = 4;

   ////////////////////////////////////////////////////////////////////////
   // Priority levels in the order of the enable pair {high, low}
   typedef enum logic [1:0] {
      LVL_OFF,
      LVL_LOW,
      LVL_MED,
      LVL_HIGH
   } icg_level_e;

   // Request presented to the core
   typedef struct packed {
      logic valid;
      logic [1:0] id;
      icg_level_e level;
   } icg_req_s;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } icg_bus_s;

endpackage

/* design/icg_edge_det.sv */
/*
 * Per-pin edge detector with selectable polarity.
 * Assumes the inputs are already synchronous to the clock.
 */
`timescale 1ns/1ps
module icg_edge_det import icg_pkg::*; #(
   parameter int W = PORTA_PINS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   input wire logic [W-1:0] pol,
   output logic [W-1:0] evt
);

   logic [W-1:0] prev_q;
   logic [W-1:0] evt_q;
   logic armed_q;

   ////////////////////////////////////////////////////////////////////////
   // Previous sample; no compare until one real sample is held, so a pin
   // that is high at reset release does not fake a rising edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= '0;
         armed_q <= 1'b0;
      end else begin
         prev_q <= din;
         armed_q <= 1'b1;
      end
   end

   // One-cycle request on the selected transition
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         wire rise = din[i] & ~prev_q[i];
         wire fall = ~din[i] & prev_q[i];
         wire hit = armed_q & (pol[i] ? rise : fall);
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               evt_q[i] <= 1'b0;
            end else begin
               evt_q[i] <= hit;
            end
         end
         a_edge_fall: assert property (@(posedge clk) disable iff (rst)
            (armed_q && !pol[i] && prev_q[i] && !din[i]) |=> evt_q[i])
            else $error("falling edge did not raise request");
         a_edge_rise: assert property (@(posedge clk) disable iff (rst)
            evt_q[i] && $past(pol[i]) |-> $past(din[i]) && !$past(prev_q[i]))
            else $error("rising-edge request without a rising edge");
      end
   endgenerate

   assign evt = evt_q;

endmodule

/* design/icg_prio_enc.sv */
/*
 * Priority selection over the four group-two sources.
 * Assumes pending bits and enable pairs come from registers in the top.
 */
`timescale 1ns/1ps
module icg_prio_enc import icg_pkg::*; #(
   parameter int N = G2_SRCS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [N-1:0] pend,
   input wire logic [N-1:0] en_high,
   input wire logic [N-1:0] en_low,
   input wire logic master_en,
   input wire logic hold,
   output icg_req_s req
);

   icg_level_e lvl [N];
   icg_level_e best_lvl;
   logic [1:0] best_id;
   icg_req_s req_q;

   ////////////////////////////////////////////////////////////////////////
   // Enable pair to level per source
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_lvl
         assign lvl[i] = icg_level_e'({en_high[i], en_low[i]});
         a_prio_top: assert property (@(posedge clk) disable iff (rst)
            req_q.valid && $past(pend[i]) |-> req_q.level >= $past(lvl[i]))
            else $error("lower level presented over higher one");
      end
   endgenerate

   // Strict compare keeps the lowest index on a tie
   always_comb begin
      best_lvl = LVL_OFF;
      best_id = 2'h0;
      for (int k = 0; k < N; k++) begin
         if (pend[k] && lvl[k] > best_lvl) begin
            best_lvl = lvl[k];
            best_id = k[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered request, dropped while the master enable is low; held for
   // the cycle after an acknowledge so the cleared source is not re-offered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_q <= '0;
      end else begin
         req_q.valid <= master_en & ~hold & (best_lvl != LVL_OFF);
         req_q.id <= best_id;
         req_q.level <= best_lvl;
      end
   end

   a_prio_gate: assert property (@(posedge clk) disable iff (rst)
      req_q.valid |-> $past(master_en) && req_q.level != LVL_OFF)
      else $error("request presented while disabled");

   assign req = req_q;

endmodule

/* design/icg_top.sv */
/*
 * Top of the group-two priority, port A edge select and shared source
 * select part of the interrupt controller, with the master enable.
 * Assumes a register master that never issues read and write together,
 * instruction strobes from the core, and synchronous pin inputs.
 */
`timescale 1ns/1ps
module icg_top import icg_pkg::*; (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [11:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic [7:0] PORTA_IN,
   input wire logic LVD_IN,
   input wire logic CMP_IN,
   input wire logic [3:0] PORTC_EVT,
   input wire logic EI_STB,
   input wire logic DI_STB,
   input wire logic INTERRUPT_RETURN_INSTRUCTION_STB,
   input wire logic CORE_ACK,
   output icg_req_s REQ,
   output logic MASTER_EN,
   output logic [7:0] PA_REQ,
   output logic IRQ_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // Register port bundle
   icg_bus_s bus;
   assign bus = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

   // Address decode
   wire hit_pend = bus.addr == OFS_G2_PEND;
   wire hit_high = bus.addr == OFS_G2_PRIO_HIGH;
   wire hit_low = bus.addr == OFS_G2_PRIO_LOW;
   wire hit_pol = bus.addr == OFS_EDGE_POL;
   wire hit_sel = bus.addr == OFS_SHARED_SEL;
   wire hit_ctrl = bus.addr == OFS_IRQ_CTRL;
   wire hit_stat = bus.addr == OFS_EDGE_STAT;
   wire hit_mask = bus.addr == OFS_EDGE_MASK;

   // Write strobes per register
   wire wr_pend = bus.wr & hit_pend;
   wire wr_high = bus.wr & hit_high;
   wire wr_low = bus.wr & hit_low;
   wire wr_pol = bus.wr & hit_pol;
   wire wr_sel = bus.wr & hit_sel;
   wire wr_ctrl = bus.wr & hit_ctrl;
   wire wr_stat = bus.wr & hit_stat;
   wire wr_mask = bus.wr & hit_mask;

   ////////////////////////////////////////////////////////////////////////
   // Plain storage registers
   logic [7:0] prio_high_q, prio_high_d;
   logic [7:0] prio_low_q, prio_low_d;
   logic [7:0] pol_q, pol_d;
   logic [7:0] sel_q, sel_d;
   logic [7:0] mask_q, mask_d;

   // Upper bits are stored as written; software keeps them zero and only
   // the low four steer the encoder
   assign prio_high_d = wr_high ? bus.wdata : prio_high_q;
   assign prio_low_d = wr_low ? bus.wdata : prio_low_q;
   assign pol_d = wr_pol ? bus.wdata : pol_q;
   assign sel_d = wr_sel ? bus.wdata : sel_q;
   assign mask_d = wr_mask ? bus.wdata : mask_q;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         prio_high_q <= RST_BYTE;
         prio_low_q <= RST_BYTE;
         pol_q <= RST_BYTE;
         sel_q <= RST_BYTE;
         mask_q <= RST_BYTE;
      end else begin
         prio_high_q <= prio_high_d;
         prio_low_q <= prio_low_d;
         pol_q <= pol_d;
         sel_q <= sel_d;
         mask_q <= mask_d;
      end
   end

   // A write lands at its strobe edge, all eight bits as given
   a_write_high: assert property (@(posedge SYS_CLK) disable iff (RST)
      wr_high |=> prio_high_q == $past(REG_WDATA))
      else $error("high enable byte not stored");

   // Low enable bits take the same path as the high ones
   a_write_low: assert property (@(posedge SYS_CLK) disable iff (RST)
      wr_low |=> prio_low_q == $past(REG_WDATA))
      else $error("low enable byte not stored");

   // Polarity byte follows a write at once
   a_write_pol: assert property (@(posedge SYS_CLK) disable iff (RST)
      wr_pol |=> pol_q == $past(REG_WDATA))
      else $error("edge polarity byte not stored");

   // Reserved select bits are kept so software reads back what it wrote
   a_write_sel: assert property (@(posedge SYS_CLK) disable iff (RST)
      wr_sel |=> sel_q == $past(REG_WDATA))
      else $error("shared select byte not stored");

   ////////////////////////////////////////////////////////////////////////
   // Shared source routing ahead of the edge detector; a switch between
   // sources at different levels is seen as an edge on purpose, which is
   // why software must disable the request before switching
   logic [7:0] src;
   logic [7:0] pa_evt;
   assign src[5:0] = PORTA_IN[5:0];
   assign src[POS_PIN6_OR_CMP] = sel_q[POS_PIN6_OR_CMP] ? CMP_IN : PORTA_IN[6];
   assign src[POS_PIN7_OR_LVD] = sel_q[POS_PIN7_OR_LVD] ? LVD_IN : PORTA_IN[7];

   icg_edge_det #(.W(PORTA_PINS)) u_edge (
      .clk(SYS_CLK),
      .rst(RST),
      .din(src),
      .pol(pol_q),
      .evt(pa_evt)
   );

   // A detector edge reaches the request through the selected path, two edges on
   a_shared_pin7: assert property (@(posedge SYS_CLK) disable iff (RST)
      sel_q[7] && $stable(sel_q[7]) && pol_q[7] && $rose(LVD_IN) |-> ##2 PA_REQ[7])
      else $error("detector edge did not raise request");

   a_shared_pin6: assert property (@(posedge SYS_CLK) disable iff (RST)
      $rose(sel_q[6]) && !$past(PORTA_IN[6]) && CMP_IN && pol_q[6]
      && $stable(pol_q[6]) |-> ##2 PA_REQ[6])
      else $error("source switch edge was suppressed");

   ////////////////////////////////////////////////////////////////////////
   // Edge status, write one to clear; a new edge in the clearing cycle wins
   logic [7:0] stat_q, stat_d;
   logic [7:0] pa_req_q;
   logic irq_q;
   wire [7:0] stat_clr = wr_stat ? bus.wdata : 8'h00;
   assign stat_d = (stat_q & ~stat_clr) | pa_evt;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         stat_q <= RST_BYTE;
         pa_req_q <= RST_BYTE;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         pa_req_q <= pa_evt;
         irq_q <= |(stat_d & mask_d);
      end
   end

   a_irq_level: assert property (@(posedge SYS_CLK) disable iff (RST)
      ##1 irq_q == |(stat_q & mask_q))
      else $error("interrupt line does not follow status and mask");

   // A new edge in the clearing cycle must survive the clear
   a_stat_set: assert property (@(posedge SYS_CLK) disable iff (RST)
      (|pa_evt) |=> (stat_q & $past(pa_evt)) == $past(pa_evt))
      else $error("edge status missed a request");

   // Write one clears a status bit when no edge competes
   a_stat_clr: assert property (@(posedge SYS_CLK) disable iff (RST)
      wr_stat && REG_WDATA[0] && !pa_evt[0] |=> !stat_q[0])
      else $error("status bit survived its clear");

   ////////////////////////////////////////////////////////////////////////
   // Group-two pending bits: set by a port C request, cleared by the
   // acknowledge of the presented source or a write of one
   logic [3:0] pend_q, pend_d;
   logic hold_q;
   icg_req_s req;
   wire [3:0] ack_clr = CORE_ACK && req.valid ? 4'(1 << req.id) : 4'h0;
   wire [3:0] sw_clr = wr_pend ? bus.wdata[3:0] : 4'h0;
   assign pend_d = (pend_q & ~(ack_clr | sw_clr)) | PORTC_EVT;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pend_q <= 4'h0;
         hold_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         hold_q <= CORE_ACK;
      end
   end

   a_pend_set: assert property (@(posedge SYS_CLK) disable iff (RST)
      PORTC_EVT[0] |=> pend_q[0])
      else $error("port C request not pending");

   a_pend_keep: assert property (@(posedge SYS_CLK) disable iff (RST)
      pend_q[1] && !CORE_ACK && !wr_pend |=> pend_q[1])
      else $error("pending bit lost without service");

   // Write one clears a pending bit unless a new request comes with it
   a_pend_clr: assert property (@(posedge SYS_CLK) disable iff (RST)
      wr_pend && REG_WDATA[2] && !PORTC_EVT[2] |=> !pend_q[2])
      else $error("pending bit survived its clear");

   // Pending bits read back in the low nibble, upper bits zero
   a_pend_read: assert property (@(posedge SYS_CLK) disable iff (RST)
      REG_RD && hit_pend |=> REG_RDATA == {4'h0, $past(pend_q)})
      else $error("pending read returned wrong data");

   ////////////////////////////////////////////////////////////////////////
   // Master enable: sets win over clears when both arrive together
   logic master_en_q, master_en_d;
   wire me_set = EI_STB | INTERRUPT_RETURN_INSTRUCTION_STB | (wr_ctrl & bus.wdata[POS_MASTER_EN]);
   wire me_clr = DI_STB | CORE_ACK | (wr_ctrl & ~bus.wdata[POS_MASTER_EN]);
   assign master_en_d = me_set ? 1'b1 : (me_clr ? 1'b0 : master_en_q);

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         master_en_q <= RST_MASTER_EN;
      end else begin
         master_en_q <= master_en_d;
      end
   end

   a_me_ack: assert property (@(posedge SYS_CLK) disable iff (RST)
      CORE_ACK && !EI_STB && !INTERRUPT_RETURN_INSTRUCTION_STB && !wr_ctrl |=> !master_en_q ##1 !REQ.valid)
      else $error("acknowledge did not drop master enable");

   a_me_set: assert property (@(posedge SYS_CLK) disable iff (RST)
      EI_STB || INTERRUPT_RETURN_INSTRUCTION_STB |=> master_en_q)
      else $error("enable instruction did not set master enable");

   // A control write alone decides the enable
   a_me_write: assert property (@(posedge SYS_CLK) disable iff (RST)
      wr_ctrl && !EI_STB && !INTERRUPT_RETURN_INSTRUCTION_STB && !DI_STB && !CORE_ACK
      |=> master_en_q == $past(REG_WDATA[POS_MASTER_EN]))
      else $error("control write did not set the enable");

   // Disable instruction clears unless a set competes in the same cycle
   a_me_di: assert property (@(posedge SYS_CLK) disable iff (RST)
      DI_STB && !EI_STB && !INTERRUPT_RETURN_INSTRUCTION_STB && !(wr_ctrl && REG_WDATA[POS_MASTER_EN])
      |=> !master_en_q)
      else $error("disable instruction did not clear the enable");

   // With no event the enable holds its value
   a_me_keep: assert property (@(posedge SYS_CLK) disable iff (RST)
      !EI_STB && !INTERRUPT_RETURN_INSTRUCTION_STB && !DI_STB && !CORE_ACK && !wr_ctrl |=> $stable(master_en_q))
      else $error("enable changed without an event");

   // The served source is not offered again before its pending bit clears
   a_req_gap: assert property (@(posedge SYS_CLK) disable iff (RST)
      CORE_ACK |=> !REQ.valid ##1 !REQ.valid)
      else $error("request offered again right after acknowledge");

   ////////////////////////////////////////////////////////////////////////
   // Priority encoder presents the winner to the core
   icg_prio_enc #(.N(G2_SRCS)) u_prio (
      .clk(SYS_CLK),
      .rst(RST),
      .pend(pend_q),
      .en_high(prio_high_q[3:0]),
      .en_low(prio_low_q[3:0]),
      .master_en(master_en_q),
      .hold(CORE_ACK | hold_q),
      .req(req)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read mux; control bits below the master enable read zero
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;
   assign rd_mux = hit_pend ? {4'h0, pend_q} :
                   hit_high ? prio_high_q :
                   hit_low ? prio_low_q :
                   hit_pol ? pol_q :
                   hit_sel ? sel_q :
                   hit_ctrl ? {master_en_q, 7'h00} :
                   hit_stat ? stat_q :
                   hit_mask ? mask_q : 8'h00;

   // Data stand only in the cycle after the read strobe, zero otherwise
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= bus.rd ? rd_mux : 8'h00;
      end
   end

   a_read_data: assert property (@(posedge SYS_CLK) disable iff (RST)
      REG_RD && hit_ctrl |=> REG_RDATA == {$past(master_en_q), 7'h00})
      else $error("control read returned wrong data");

   // Read data are zero outside the cycle after a read strobe
   a_rdata_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
      !REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data stand outside their cycle");

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   assign REG_RDATA = rdata_q;
   assign REQ = req;
   assign MASTER_EN = master_en_q;
   assign PA_REQ = pa_req_q;
   assign IRQ_OUT = irq_q;

endmodule

/* tb/icg_core_model.sv */
/*
 * Core stand-in that takes group-two requests and acknowledges them.
 * Assumes one request at a time on the single system clock.
 */
`timescale 1ns/1ps
module icg_core_model import icg_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire icg_req_s req,
   input wire logic slow,
   output logic ack
);
   logic [2:0] wait_q;
   // One-cycle ack, only while valid; slow mode lets the request stand longer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q <= 3'h0;
         ack <= 1'b0;
      end else if (ack || req.valid !== 1'b1) begin
         wait_q <= 3'h0;
         ack <= 1'b0;
      end else begin
         wait_q <= wait_q + 3'h1;
         ack <= (wait_q >= (slow ? 3'h4 : 3'h0));
      end
   end
endmodule

/* tb/tb_icg_top.sv */
/*
 * Self-checking bench for the group-two priority, edge select and shared
 * source part of the interrupt controller.
 * Assumes the package, the design files and the core stand-in compile first.
 */
`timescale 1ns/1ps
module tb_icg_top import icg_pkg::*; ();
   logic SYS_CLK, RST, REG_WR, REG_RD, LVD_IN, CMP_IN, EI_STB, DI_STB, INTERRUPT_RETURN_INSTRUCTION_STB;
   logic slow;
   logic [11:0] REG_ADDR;
   logic [7:0] REG_WDATA, PORTA_IN;
   logic [3:0] PORTC_EVT;
   logic [9:0] pins;
   wire logic [7:0] REG_RDATA, PA_REQ;
   wire logic MASTER_EN, IRQ_OUT, CORE_ACK;
   wire icg_req_s REQ;
   int n_mismatch, total_checks;
   logic [3:0] served[$];

   icg_top u_dut (.SYS_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
      .PORTA_IN, .LVD_IN, .CMP_IN, .PORTC_EVT, .EI_STB, .DI_STB, .INTERRUPT_RETURN_INSTRUCTION_STB, .CORE_ACK,
      .REQ, .MASTER_EN, .PA_REQ, .IRQ_OUT);
   icg_core_model u_core (.clk(SYS_CLK), .rst(RST), .req(REQ), .slow(slow), .ack(CORE_ACK));

   // Clock at 4 ns
   initial begin
      SYS_CLK = 1'b0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end

   // Record what the core took, as {id, level}
   always @(posedge SYS_CLK) begin
      if (CORE_ACK === 1'b1 && REQ.valid === 1'b1) served.push_back({REQ.id, REQ.level});
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
      @(posedge SYS_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 chk(nm, REG_RDATA, e);
   endtask

   task automatic strobe(input int k);
      @(posedge SYS_CLK);
      EI_STB <= (k == 0);
      INTERRUPT_RETURN_INSTRUCTION_STB <= (k == 1);
      DI_STB <= (k == 3);
      @(posedge SYS_CLK);
      {EI_STB, INTERRUPT_RETURN_INSTRUCTION_STB, DI_STB} <= 3'h0;
   endtask

   task automatic drive_pins();
      @(posedge SYS_CLK);
      {LVD_IN, CMP_IN, PORTA_IN} <= pins;
      repeat (3) @(posedge SYS_CLK);
   endtask

   task automatic acc_req(input string nm, input logic [7:0] e);
      logic [7:0] acc;
      acc = 8'h00;
      repeat (3) begin
         @(posedge SYS_CLK);
         #1 acc = acc | PA_REQ;
      end
      chk(nm, acc, e);
   endtask

   // Level the pin logic sees once the shared mux has chosen
   function automatic logic [7:0] eff(input logic [9:0] r, input logic [1:0] s);
      return {s[1] ? r[9] : r[7], s[0] ? r[8] : r[6], r[5:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Random pin traffic against a fixed polarity and shared selection
   task automatic edge_run(input int steps);
      logic [7:0] pol, prev, cur, exp1, exp2;
      logic [1:0] s;
      pol = $urandom;
      s = $urandom;
      wr(OFS_EDGE_POL, pol);
      wr(OFS_EDGE_MASK, 8'h00);
      wr(OFS_SHARED_SEL, {s, 6'h00});
      rchk("edge_pol", OFS_EDGE_POL, pol);
      rchk("shared_sel", OFS_SHARED_SEL, {s, 6'h00});
      prev = eff(pins, s);
      for (int k = 0; k <= steps; k++) begin
         @(posedge SYS_CLK);
         pins = $urandom;
         {LVD_IN, CMP_IN, PORTA_IN} <= pins;
         // A pin change reaches the request output two edges after it is driven
         #1 if (k > 1) chk("pa_req", PA_REQ, exp2);
         cur = eff(pins, s);
         exp2 = exp1;
         exp1 = (pol & cur & ~prev) | (~pol & ~cur & prev);
         prev = cur;
      end
   endtask

   // Group-two sources served in priority order, then the disabled never
   task automatic g2_run(input logic [3:0] hi, input logic [3:0] lo, input logic sl);
      logic [3:0] q[$];
      int cnt;
      slow <= sl;
      wr(OFS_G2_PRIO_HIGH, {4'h0, hi});
      wr(OFS_G2_PRIO_LOW, {4'h0, lo});
      rchk("prio_high", OFS_G2_PRIO_HIGH, {4'h0, hi});
      rchk("prio_low", OFS_G2_PRIO_LOW, {4'h0, lo});
      @(posedge SYS_CLK);
      PORTC_EVT <= 4'hf;
      @(posedge SYS_CLK);
      PORTC_EVT <= 4'h0;
      rchk("pending", OFS_G2_PEND, 8'h0f);
      for (int l = 3; l > 0; l--) begin
         for (int i = 0; i < 4; i++) if ({hi[i], lo[i]} == l) q.push_back({i[1:0], l[1:0]});
      end
      served.delete();
      for (int n = 0; n <= q.size(); n++) begin
         if (n % 3 == 2) wr(OFS_IRQ_CTRL, 8'h80);
         else strobe(n % 3);
         cnt = 0;
         while (served.size() <= n && cnt < 30) begin
            @(posedge SYS_CLK);
            #1 cnt++;
         end
         if (n < q.size()) chk("en_after_ack", {7'h0, MASTER_EN}, 8'h00);
      end
      chk("served_n", served.size(), q.size());
      for (int n = 0; n < q.size(); n++) chk("served", served[n], q[n]);
      strobe(3);
      wr(OFS_G2_PEND, 8'h0f);
      rchk("pend_clr", OFS_G2_PEND, 8'h00);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog; the whole run needs well under this
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      logic [11:0] regs[6];
      regs = '{OFS_G2_PEND, OFS_G2_PRIO_HIGH, OFS_G2_PRIO_LOW, OFS_EDGE_POL,
         OFS_SHARED_SEL, OFS_IRQ_CTRL};
      {REG_WR, REG_RD, EI_STB, DI_STB, INTERRUPT_RETURN_INSTRUCTION_STB, slow} = 6'h00;
      {REG_ADDR, REG_WDATA, PORTC_EVT} = 24'h0;
      pins = 10'h000;
      {LVD_IN, CMP_IN, PORTA_IN} = pins;
      void'($urandom(19));
      RST = 1'b1;
      repeat (2) @(posedge SYS_CLK);
      RST <= 1'b0;
      foreach (regs[i]) rchk("reset_val", regs[i], RST_BYTE);
      wr(12'h100, 8'hff);
      rchk("unmapped", 12'h100, 8'h00);
      wr(OFS_IRQ_CTRL, 8'h80);
      rchk("ctrl_set", OFS_IRQ_CTRL, 8'h80);
      strobe(3);
      rchk("ctrl_di", OFS_IRQ_CTRL, 8'h00);
      $display("test registers done");
      repeat (4) edge_run(40);
      $display("test edges done");
      // Source switch with differing levels makes its own edge
      pins = 10'h300;
      drive_pins();
      wr(OFS_EDGE_POL, 8'hff);
      wr(OFS_SHARED_SEL, 8'h00);
      repeat (2) @(posedge SYS_CLK);
      wr(OFS_SHARED_SEL, 8'hc0);
      acc_req("switch_rise", 8'hc0);
      wr(OFS_SHARED_SEL, 8'h00);
      acc_req("switch_fall", 8'h00);
      $display("test source switch done");
      // Sticky status, mask and level output
      wr(OFS_EDGE_POL, 8'h00);
      pins = 10'h0ff;
      drive_pins();
      wr(OFS_EDGE_STAT, 8'hff);
      wr(OFS_EDGE_MASK, 8'h01);
      pins[1] = 1'b0;
      drive_pins();
      rchk("stat", OFS_EDGE_STAT, 8'h02);
      chk("irq_masked", {7'h0, IRQ_OUT}, 8'h00);
      pins[0] = 1'b0;
      drive_pins();
      chk("irq_on", {7'h0, IRQ_OUT}, 8'h01);
      wr(OFS_EDGE_MASK, 8'h00);
      repeat (2) @(posedge SYS_CLK);
      #1 chk("irq_mask0", {7'h0, IRQ_OUT}, 8'h00);
      wr(OFS_EDGE_MASK, 8'h01);
      wr(OFS_EDGE_STAT, 8'h01);
      repeat (2) @(posedge SYS_CLK);
      #1 chk("irq_clr", {7'h0, IRQ_OUT}, 8'h00);
      rchk("stat_left", OFS_EDGE_STAT, 8'h02);
      $display("test interrupt done");
      g2_run(4'h3, 4'h5, 1'b0);
      repeat (3) g2_run($urandom, $urandom, $urandom);
      $display("test group two done");
      report_and_stop();
   end
endmodule
